//--- logic/lvdi_ctrl.sv
// lvdi_ctrl: low voltage detector control, mode and level select, event flags
// assumes: analog comparators outside; cpu writes come as byte or bit strobes
`timescale 1ns/1ps
module lvdi_ctrl
  import lvdi_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       power_on_reset,
  input  wire logic       default_start_disable,
  input  wire logic       supply_below,
  input  wire logic       external_below,
  input  wire logic       mode_byte_wr,
  input  wire logic [7:0] mode_byte_data,
  input  wire logic       mode_bit_wr,
  input  wire logic [2:0] mode_bit_sel,
  input  wire logic       mode_bit_val,
  input  wire logic       level_wr,
  input  wire logic [3:0] level_wr_data,
  input  wire logic       mask_wr,
  input  wire logic       mask_wr_val,
  input  wire logic       req_clear,
  input  wire logic       cause_clear,
  output logic      [7:0] detect_mode_reg,
  output logic      [3:0] detect_level_select_reg,
  output logic      [3:0] supply_threshold,
  output logic            source_select,
  output logic            detector_enable,
  output logic            detector_run,
  output logic            detect_irq,
  output logic            detect_irq_request_flag,
  output logic            detect_irq_mask,
  output logic            detect_reset,
  output logic            detector_reset_cause_flag
);
  import lvdi_pkg::*;

  lvdi_sync_if sif ();

  logic [7:0] mode_q;
  logic [3:0] level_q;
  logic       mask_q;
  logic       req_q;
  logic       irq_q;
  logic       rst_req_q;
  logic       cause_q;
  logic       run_q;
  logic       default_q;
  logic       enable_fall;
  logic       level_chg;
  logic       src_chg;
  logic       event_hit;
  logic       drop_hit;
  logic       any_irq;
  logic       is_action_rst;

  // option level caught on each clocked reset
  always_ff @(posedge clock)
  begin
    if (reset)
      default_q <= ~default_start_disable;
  end

  assign is_action_rst = mode_q[MODE_ACTION_BIT];

  // mode register: software bits plus hardware level flag
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      if (!default_start_disable)
        mode_q <= MODE_DEFAULT_VAL;
      else
        mode_q <= MODE_RESET_VAL;
    end
    else
    begin
      if (mode_byte_wr)
        mode_q[7:1] <= mode_byte_data[7:1] & MODE_WMASK[7:1];
      else if (mode_bit_wr && MODE_WMASK[mode_bit_sel])
        mode_q[mode_bit_sel] <= mode_bit_val;
      if (run_q)
        mode_q[MODE_LEVEL_BIT] <= sif.stable_below;
      else
        mode_q[MODE_LEVEL_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      if (!default_start_disable)
        level_q <= LEVEL_DEFAULT_VAL;
      else
        level_q <= LEVEL_RESET_VAL;
    end
    else if (level_wr)
      level_q <= level_wr_data;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      mask_q <= 1'b1;
    else if (mask_wr)
      mask_q <= mask_wr_val;
  end

  // unless default start was selected at the last reset, a settle window after enable hides start-up transients from the filter
  logic [CNT_W-1:0] settle_q;
  always_ff @(posedge clock)
  begin
    if (reset || !mode_q[MODE_ENABLE_BIT])
    begin
      settle_q <= '0;
      run_q    <= 1'b0;
    end
    else if (!run_q)
    begin
      if (settle_q == CNT_W'(SETTLE_CYC - 1) || default_q)
        run_q <= 1'b1;
      else
        settle_q <= settle_q + CNT_W'(1);
    end
  end

  // mux before the sampler; a source change restarts qualification
  assign sif.raw_below = mode_q[MODE_SOURCE_BIT] ? external_below : supply_below;
  assign sif.run       = run_q && !src_chg;

  lvdi_filter u_filter
  (
    .clock (clock),
    .reset (reset),
    .sif   (sif)
  );

  logic prev_en_q;
  logic [3:0] prev_level_q;
  logic prev_src_q;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      prev_en_q    <= 1'b0;
      prev_level_q <= LEVEL_RESET_VAL;
      prev_src_q   <= 1'b0;
    end
    else
    begin
      prev_en_q    <= run_q;
      prev_level_q <= level_q;
      prev_src_q   <= mode_q[MODE_SOURCE_BIT];
    end
  end

  assign enable_fall = prev_en_q && !run_q;
  assign level_chg   = run_q && (prev_level_q != level_q);
  assign src_chg     = prev_src_q != mode_q[MODE_SOURCE_BIT];
  // both directions of a qualified change count
  assign event_hit   = run_q && sif.changed;
  // turning off while below looks like a rise back above
  assign drop_hit    = enable_fall && mode_q[MODE_LEVEL_BIT];
  assign any_irq     = !is_action_rst && (event_hit || drop_hit || level_chg);

  always_ff @(posedge clock)
  begin
    if (reset)
      irq_q <= 1'b0;
    else
      irq_q <= any_irq;
  end

  // set wins over clear
  always_ff @(posedge clock)
  begin
    if (reset)
      req_q <= 1'b0;
    else if (any_irq)
      req_q <= 1'b1;
    else if (req_clear)
      req_q <= 1'b0;
  end

  // reset action: held while the qualified level stays below
  always_ff @(posedge clock)
  begin
    if (reset)
      rst_req_q <= 1'b0;
    else
      rst_req_q <= run_q && is_action_rst && sif.stable_below;
  end

  // cause flag survives ordinary reset, cleared by power-on or software
  always_ff @(posedge clock)
  begin
    if (power_on_reset)
      cause_q <= 1'b0;
    else if (rst_req_q)
      cause_q <= 1'b1;
    else if (cause_clear)
      cause_q <= 1'b0;
  end

  assign detect_mode_reg           = mode_q;
  assign detect_level_select_reg   = level_q;
  assign supply_threshold          = level_q;
  assign source_select             = mode_q[MODE_SOURCE_BIT];
  assign detector_enable           = mode_q[MODE_ENABLE_BIT];
  assign detector_run              = run_q;
  assign detect_irq                = irq_q;
  assign detect_irq_request_flag   = req_q;
  assign detect_irq_mask           = mask_q;
  assign detect_reset              = rst_req_q;
  assign detector_reset_cause_flag = cause_q;
endmodule

//--- logic/lvdi_filter.sv
// lvdi_filter: three-flop sampler plus minimum pulse width qualifier
// assumes: raw comparator level is asynchronous to clock
`timescale 1ns/1ps
module lvdi_filter
  import lvdi_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  lvdi_sync_if.filt sif
);
  logic [2:0]       sync_q;
  logic [CNT_W-1:0] cnt_q;
  logic             stable_q;
  logic             changed_q;
  logic             agree;

  // stage 0 feeds stage 1 only
  always_ff @(posedge clock)
  begin
    if (reset)
      sync_q <= 3'h0;
    else
      sync_q <= {sync_q[1], sync_q[0], sif.raw_below};
  end

  assign agree = (sync_q[1] == sync_q[2]);

  // an excursion counts only after it has held the whole minimum pulse
  always_ff @(posedge clock)
  begin
    if (reset || !sif.run)
    begin
      cnt_q     <= '0;
      stable_q  <= 1'b0;
      changed_q <= 1'b0;
    end
    else
    begin
      changed_q <= 1'b0;
      if (!agree || sync_q[2] == stable_q)
        cnt_q <= '0;
      else if (cnt_q == CNT_W'(MIN_PULSE_CYC - 1))
      begin
        cnt_q     <= '0;
        stable_q  <= sync_q[2];
        changed_q <= 1'b1;
      end
      else
        cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  assign sif.stable_below = stable_q;
  assign sif.changed      = changed_q;
endmodule

//--- logic/lvdi_pkg.sv
// lvdi_pkg: constants for the low voltage detect interrupt control block
// assumes: 200 mhz device clock, synchronous active high reset
package lvdi_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned MIN_PULSE_US     = 200;
  localparam int unsigned MIN_PULSE_CYC    = MIN_PULSE_US * CLK_MHZ;
  localparam int unsigned SETTLE_US        = 10;
  localparam int unsigned SETTLE_CYC       = SETTLE_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 16;

  localparam int unsigned MODE_ENABLE_BIT  = 7;
  localparam int unsigned MODE_SOURCE_BIT  = 2;
  localparam int unsigned MODE_ACTION_BIT  = 1;
  localparam int unsigned MODE_LEVEL_BIT   = 0;

  localparam logic [7:0] MODE_RESET_VAL    = 8'h00;
  localparam logic [7:0] MODE_DEFAULT_VAL  = 8'h82;
  localparam logic [3:0] LEVEL_RESET_VAL   = 4'h0;
  localparam logic [3:0] LEVEL_DEFAULT_VAL = 4'he;
  localparam logic [7:0] MODE_WMASK        = 8'h86;
endpackage

//--- logic/lvdi_sync_if.sv
// lvdi_sync_if: carries the comparator sample between filter and control
// assumes: one clock domain
`timescale 1ns/1ps
interface lvdi_sync_if;
  logic raw_below;
  logic stable_below;
  logic changed;
  logic run;
  modport filt (input raw_below, input run, output stable_below, output changed);
  modport ctrl (output raw_below, output run, input stable_below, input changed);
endinterface

//--- test/lvdi_comparator_model.sv
// stand-in for the analog comparators
// assumes: bench moves the level codes just after a clock edge
`timescale 1ns/1ps
module lvdi_comparator_model
  import lvdi_pkg::*;
(
  input  wire logic [3:0] supply_code,
  input  wire logic       ext_low,
  input  wire logic [3:0] supply_threshold,
  output logic            supply_below,
  output logic            external_below
);
  // strictly under the threshold counts as below
  assign supply_below   = supply_code < supply_threshold;
  assign external_below = ext_low;
endmodule

//--- test/lvdi_ctrl_asserts.sv
// checker on the ports of lvdi_ctrl
// assumes: bound from the bench top file
`timescale 1ns/1ps
module lvdi_ctrl_asserts
  import lvdi_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       default_start_disable,
  input wire logic       mode_byte_wr,
  input wire logic [7:0] mode_byte_data,
  input wire logic [7:0] detect_mode_reg,
  input wire logic [3:0] detect_level_select_reg,
  input wire logic [3:0] supply_threshold,
  input wire logic       source_select,
  input wire logic       detector_enable,
  input wire logic       detector_run,
  input wire logic       detect_irq,
  input wire logic       detect_irq_request_flag,
  input wire logic       detect_irq_mask
);
  default clocking cb @(posedge clock);
  endclocking
  property p_mask; reset |=> detect_irq_mask && !detect_irq && !detect_irq_request_flag; endproperty
  a_mask: assert property (p_mask) else $error("mask after reset");
  property p_dflt; reset && !default_start_disable |=> detect_mode_reg == MODE_DEFAULT_VAL
    && detect_level_select_reg == LEVEL_DEFAULT_VAL; endproperty
  a_dflt: assert property (p_dflt) else $error("default start");
  property p_wr; disable iff (reset) mode_byte_wr |=>
    (detect_mode_reg & MODE_WMASK) == ($past(mode_byte_data) & MODE_WMASK); endproperty
  a_wr: assert property (p_wr) else $error("byte write");
  property p_src; source_select == detect_mode_reg[MODE_SOURCE_BIT]
    && detector_enable == detect_mode_reg[MODE_ENABLE_BIT]; endproperty
  a_src: assert property (p_src) else $error("mode bits");
  property p_thr; supply_threshold == detect_level_select_reg; endproperty
  a_thr: assert property (p_thr) else $error("threshold");
  property p_off; disable iff (reset) $fell(detector_enable) |-> ##[0:2] !detector_run; endproperty
  a_off: assert property (p_off) else $error("still running");
  property p_lvl; disable iff (reset) !detector_run && !$past(detector_run)
    |-> !detect_mode_reg[MODE_LEVEL_BIT]; endproperty
  a_lvl: assert property (p_lvl) else $error("level flag idle");
  property p_req; disable iff (reset) detect_irq |=> detect_irq_request_flag; endproperty
  a_req: assert property (p_req) else $error("request flag");
  property p_pulse; disable iff (reset) detect_irq |=> !detect_irq; endproperty
  a_pulse: assert property (p_pulse) else $error("irq width");
endmodule

//--- test/lvdi_ctrl_bench.sv
// bench for lvdi_ctrl with comparator model
// assumes: 200 mhz clock, full filter length
`timescale 1ns/1ps
module lvdi_ctrl_bench;
  import lvdi_pkg::*;
  // mode data, level, expected mode
  localparam logic [19:0] ROWS [4] = '{20'hff386, 20'h01700, 20'h04a04, 20'h02002};
  logic       clock = 1'b0, reset = 1'b1, power_on_reset = 1'b1, default_start_disable = 1'b0;
  logic       mode_byte_wr = 1'b0, mode_bit_wr = 1'b0, mode_bit_val = 1'b0, level_wr = 1'b0;
  logic       mask_wr = 1'b0, mask_wr_val = 1'b0, req_clear = 1'b0, ext_low = 1'b0;
  logic [7:0] mode_byte_data = 8'h00, detect_mode_reg;
  logic [3:0] level_wr_data = 4'h0, supply_code = 4'hf, detect_level_select_reg;
  logic [3:0] supply_threshold;
  logic [2:0] mode_bit_sel = 3'h0;
  logic       supply_below, external_below, source_select, detector_enable, detector_run;
  logic       detect_irq, detect_irq_request_flag, detect_irq_mask, detect_reset;
  logic       detector_reset_cause_flag;
  int         mismatches = 0, tests_run = 0, cycles = 0, n;
  always #2.5 clock = ~clock;
  lvdi_comparator_model i_lvdi_comparator_model (.supply_code, .ext_low, .supply_threshold,
    .supply_below, .external_below);
  lvdi_ctrl i_lvdi_ctrl (.clock, .reset, .power_on_reset, .default_start_disable, .supply_below,
    .external_below, .mode_byte_wr, .mode_byte_data, .mode_bit_wr, .mode_bit_sel,
    .mode_bit_val, .level_wr, .level_wr_data, .mask_wr, .mask_wr_val, .req_clear,
    .cause_clear(1'b0), .detect_mode_reg, .detect_level_select_reg, .supply_threshold,
    .source_select, .detector_enable, .detector_run, .detect_irq, .detect_irq_request_flag,
    .detect_irq_mask, .detect_reset, .detector_reset_cause_flag);
  task conclude;
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // k: 0 byte, 1 level, 2 mask, 3 req clear, 4 bit write with sel d[3:1]
  task poke(input int k, input logic [7:0] d);
    @(posedge clock);
    mode_byte_data <= d;
    level_wr_data <= d[3:0];
    mask_wr_val <= d[0];
    mode_bit_sel <= d[3:1];
    mode_bit_val <= d[0];
    {mode_byte_wr, level_wr, mask_wr, req_clear, mode_bit_wr} <= 5'h1 << (4 - k);
    @(posedge clock);
    {mode_byte_wr, level_wr, mask_wr, req_clear, mode_bit_wr} <= 5'h0;
    #1;
  endtask
  task do_reset(input logic dsd);
    @(posedge clock);
    reset <= 1'b1;
    default_start_disable <= dsd;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    #1;
  endtask
  task wait_irq(input int lim);
    n = 0;
    while (detect_irq !== 1'b1 && n < lim)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    cmp({7'h0, detect_irq}, 8'h01);
  endtask
  // filter length is fixed, so the ceiling covers two full excursions
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 95000)
    begin
      mismatches++;
      conclude();
    end
  end
  initial
  begin
    do_reset(1'b0);
    power_on_reset <= 1'b0;
    cmp(detect_mode_reg, MODE_DEFAULT_VAL);
    cmp({detect_level_select_reg, 2'h0, detect_irq_mask, detect_irq_request_flag}, 8'he2);
    @(posedge clock);
    #1;
    cmp({7'h0, detector_run}, 8'h01);
    poke(4, 8'h02);
    poke(2, 8'h00);
    cmp({detect_mode_reg[7:1], detect_irq_mask}, 8'h80);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      supply_code <= (i == 0) ? 4'h0 : 4'hf;
      wait_irq(40100);
      cmp({7'h0, n >= 40000}, 8'h01);
      @(posedge clock);
      #1;
      cmp({6'h0, detect_irq_request_flag, detect_mode_reg[0]}, {7'h1, i == 0});
      cmp({6'h0, detect_reset, detector_reset_cause_flag}, 8'h00);
      poke(3, 8'h00);
    end
    poke(1, 8'h09);
    wait_irq(10);
    poke(0, 8'h00);
    repeat (2) @(posedge clock);
    #1;
    cmp({detect_mode_reg[7:1], detector_run}, 8'h00);
    do_reset(1'b1);
    cmp({detect_mode_reg[7:1], detect_irq_mask}, 8'h01);
    poke(4, 8'h01);
    cmp(detect_mode_reg, 8'h00);
    foreach (ROWS[i])
    begin
      poke(0, ROWS[i][19:12]);
      poke(1, {4'h0, ROWS[i][11:8]});
      cmp(detect_mode_reg, ROWS[i][7:0]);
      cmp({source_select, detector_enable, 2'h0, supply_threshold},
        {ROWS[i][2], ROWS[i][7], 2'h0, ROWS[i][11:8]});
    end
    conclude();
  end
endmodule
bind lvdi_ctrl lvdi_ctrl_asserts i_lvdi_ctrl_asserts (.clock, .reset, .default_start_disable,
  .mode_byte_wr, .mode_byte_data, .detect_mode_reg, .detect_level_select_reg,
  .supply_threshold, .source_select, .detector_enable, .detector_run, .detect_irq,
  .detect_irq_request_flag, .detect_irq_mask);
